// ---- plc_map.vh ----
/*
 * Register map, field layout, reset values and timing counts for the
 * loop source, enable and lock control block.
 * Assumes a 50 MHz system clock and APB word-addressed registers.
 */
`ifndef PLC_MAP_VH
`define PLC_MAP_VH

// Register indices; byte address is four times the index
`define PLC_IDX_FB_DIV 16'hf000
`define PLC_IDX_PRESCALE 16'hf001
`define PLC_IDX_SRC_SEL 16'hf002
`define PLC_IDX_RUN_CTRL 16'hf003
`define PLC_IDX_LOCK_STAT 16'hf004
`define PLC_IDX_CLK_OUT 16'hf005

// Address width of the APB byte address
`define PLC_AW 18

// Field positions and widths
`define PLC_FB_DIV_W 7
`define PLC_PRESCALE_W 2
`define PLC_SRC_BIT 0
`define PLC_RUN_BIT 0
`define PLC_LOCK_BIT 0
`define PLC_CLOCK_OUTPUT_PIN_EN_BIT 0
`define PLC_CLOCK_OUTPUT_PIN_RATE_LSB 1
`define PLC_CLOCK_OUTPUT_PIN_RATE_W 2

// Reset values
`define PLC_FB_DIV_RST 7'h60
`define PLC_PRESCALE_RST 2'h0
`define PLC_SRC_RST 1'h0
`define PLC_RUN_RST 1'h0
`define PLC_CLOCK_OUTPUT_PIN_RST 3'h0

// Timing: feedback settle time in microseconds, clock in MHz
`define PLC_SETTLE_US 100
`define PLC_CLK_MHZ 50
`define PLC_SETTLE_CYC (`PLC_SETTLE_US * `PLC_CLK_MHZ)

`endif

// ---- plc_ctrl.v ----
/*
 * Loop source select, loop enable with staged settings, and lock flag,
 * as an APB slave with a model of the loop's lock acquisition.
 * Assumes all inputs are synchronous to clk and a zero-wait APB master.
 */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "plc_map.vh"

// Operation
// R1: Source bit 0: 0 picks master clock pin, 1 picks loop output.
// R2: Written source choice waits until enable bit rises from 0 to 1.
// R3: Enable rising edge loads divider, prescale, source, clock-output together.
// R4: No lock attempt while the enable bit is cleared.
// R5: Enable cleared means no loop output clock; dependent clocks stay idle.
// R6: Lock flag in bit 0 is read only; writes leave it unchanged.
// R7: Lock needs stable input, valid settings, enable, and settled feedback.
// R8: Software polls the lock flag instead of waiting a fixed time.
// R9: Software normally selects the loop output as core clock.
// R10: After reset source, enable and lock bits are all zero.
// R11: Prescale codes 00,01,10,11 divide master clock by 1,2,4,8.
// R12: Feedback divider is a 7-bit multiplier, default 96.
module plc_ctrl #(
  parameter SETTLE_CYC = `PLC_SETTLE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PLC_AW-1:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // Loop and master clock status
  input wire master_clock_stable,
  // Active settings toward the clock tree
  output reg core_clock_select,
  output reg loop_run,
  output reg [`PLC_FB_DIV_W-1:0] feedback_multiplier,
  output reg [`PLC_PRESCALE_W-1:0] prescale_setting,
  output reg loop_ref_tick,
  output reg loop_clock_run,
  output reg clock_output_pin_oe,
  output reg [`PLC_CLOCK_OUTPUT_PIN_RATE_W-1:0] clock_output_rate,
  output reg loop_locked
);

  localparam ST_OFF = 2'h0;
  localparam ST_ACQ = 2'h1;
  localparam ST_LOCK = 2'h2;

  // Word-index match of the APB byte address
  function hit;
    input [`PLC_AW-1:0] a;
    input [15:0] idx;
    begin
      hit = (a[1:0] == 2'h0) && (a[`PLC_AW-1:2] == idx);
    end
  endfunction

  // Terminal count of the prescale divider for a code
  function [2:0] div_last;
    input [`PLC_PRESCALE_W-1:0] code;
    begin
      case (code)
        2'h0: div_last = 3'h0;
        2'h1: div_last = 3'h1;
        2'h2: div_last = 3'h3;
        default: div_last = 3'h7;
      endcase
    end
  endfunction

  // Staged registers as software sees them
  reg [`PLC_FB_DIV_W-1:0] fb_div_q;
  reg [`PLC_PRESCALE_W-1:0] prescale_q;
  reg src_sel_q;
  reg run_q;
  reg [2:0] clock_output_pin_q;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] settle_q;
  reg [2:0] div_cnt_q;

  wire wr_en;
  wire rd_en;
  wire mapped;
  wire run_rise;
  wire settings_ok;

  // Zero-wait slave; errors only on unmapped words
  assign pready = 1'b1;
  assign mapped = hit(paddr, `PLC_IDX_FB_DIV) |
                  hit(paddr, `PLC_IDX_PRESCALE) |
                  hit(paddr, `PLC_IDX_SRC_SEL) |
                  hit(paddr, `PLC_IDX_RUN_CTRL) |
                  hit(paddr, `PLC_IDX_LOCK_STAT) |
                  hit(paddr, `PLC_IDX_CLK_OUT);
  assign pslverr = psel & penable & ~mapped;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign run_rise = wr_en & hit(paddr, `PLC_IDX_RUN_CTRL) &
                    pwdata[`PLC_RUN_BIT] & ~run_q;
  // Zero multiplier cannot lock
  assign settings_ok = (feedback_multiplier != {`PLC_FB_DIV_W{1'b0}});

  // Software-visible registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fb_div_q <= `PLC_FB_DIV_RST; // R12
      prescale_q <= `PLC_PRESCALE_RST;
      src_sel_q <= `PLC_SRC_RST; // R10
      run_q <= `PLC_RUN_RST; // R10
      clock_output_pin_q <= `PLC_CLOCK_OUTPUT_PIN_RST;
    end else if (wr_en) begin
      if (hit(paddr, `PLC_IDX_FB_DIV))
        fb_div_q <= pwdata[`PLC_FB_DIV_W-1:0]; // R12
      if (hit(paddr, `PLC_IDX_PRESCALE))
        prescale_q <= pwdata[`PLC_PRESCALE_W-1:0];
      if (hit(paddr, `PLC_IDX_SRC_SEL))
        src_sel_q <= pwdata[`PLC_SRC_BIT]; // R2
      if (hit(paddr, `PLC_IDX_RUN_CTRL))
        run_q <= pwdata[`PLC_RUN_BIT];
      if (hit(paddr, `PLC_IDX_CLK_OUT))
        clock_output_pin_q <= pwdata[2:0];
    end
  end

  // Active copies except loop_run load only on the enable rising edge
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_clock_select <= `PLC_SRC_RST; // R10
      feedback_multiplier <= `PLC_FB_DIV_RST;
      prescale_setting <= `PLC_PRESCALE_RST;
      clock_output_pin_oe <= 1'b0;
      clock_output_rate <= 2'h0;
      loop_run <= 1'b0;
    end else begin
      loop_run <= run_q;
      if (run_rise) begin
        core_clock_select <= src_sel_q; // R1
        feedback_multiplier <= fb_div_q; // R3
        prescale_setting <= prescale_q; // R3
        clock_output_pin_oe <= clock_output_pin_q[`PLC_CLOCK_OUTPUT_PIN_EN_BIT]; // R3
        clock_output_rate <=
          clock_output_pin_q[`PLC_CLOCK_OUTPUT_PIN_RATE_LSB +: `PLC_CLOCK_OUTPUT_PIN_RATE_W]; // R3
      end
    end
  end

  // Reference divider ahead of the loop; cleared when the loop is off
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= 3'h0;
      loop_ref_tick <= 1'b0;
    end else if (!loop_run) begin
      div_cnt_q <= 3'h0; // R4
      loop_ref_tick <= 1'b0;
    end else if (div_cnt_q >= div_last(prescale_setting)) begin
      div_cnt_q <= 3'h0; // R11
      loop_ref_tick <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1; // R11
      loop_ref_tick <= 1'b0;
    end
  end

  // Lock acquisition
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (loop_run && master_clock_stable && settings_ok)
          state_d = ST_ACQ; // R4
      end
      ST_ACQ: begin
        if (!loop_run || !master_clock_stable || !settings_ok)
          state_d = ST_OFF;
        else if (settle_q >= SETTLE_CYC[15:0] - 16'h1)
          state_d = ST_LOCK; // R7
      end
      ST_LOCK: begin
        if (!loop_run || !master_clock_stable || !settings_ok)
          state_d = ST_OFF; // R7
      end
      default: state_d = ST_OFF;
    endcase
    // New settings mean a fresh acquisition
    if (run_rise)
      state_d = ST_OFF;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_OFF;
      settle_q <= 16'h0;
      loop_locked <= 1'b0; // R10
      loop_clock_run <= 1'b0;
    end else begin
      state_q <= state_d;
      settle_q <= (state_q == ST_ACQ && state_d == ST_ACQ) ?
                  settle_q + 16'h1 : 16'h0;
      loop_locked <= (state_d == ST_LOCK); // R7
      loop_clock_run <= run_q; // R5
    end
  end

  // Read data; reserved bits read zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0;
      if (hit(paddr, `PLC_IDX_FB_DIV))
        prdata <= {25'h0, fb_div_q};
      if (hit(paddr, `PLC_IDX_PRESCALE))
        prdata <= {30'h0, prescale_q};
      if (hit(paddr, `PLC_IDX_SRC_SEL))
        prdata <= {31'h0, src_sel_q};
      if (hit(paddr, `PLC_IDX_RUN_CTRL))
        prdata <= {31'h0, run_q};
      if (hit(paddr, `PLC_IDX_LOCK_STAT))
        prdata <= {31'h0, loop_locked}; // R6
      if (hit(paddr, `PLC_IDX_CLK_OUT))
        prdata <= {29'h0, clock_output_pin_q};
    end else if (rd_en && hit(paddr, `PLC_IDX_LOCK_STAT)) begin
      prdata <= {31'h0, loop_locked}; // R6
    end
  end

endmodule // plc_ctrl
`default_nettype wire

// ---- plc_ctrl_sva.sv ----
/* Checker for plc_ctrl: staging, lock and APB answer relations.
   Assumes plc_map.vh and a zero-wait APB slave on the ports. */
`timescale 1ns/1ns
`default_nettype none
`include "plc_map.vh"
module plc_ctrl_sva #(
  parameter SETTLE_CYC = `PLC_SETTLE_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`PLC_AW-1:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // Loop side
  input wire master_clock_stable,
  input wire core_clock_select,
  input wire loop_run,
  input wire [`PLC_FB_DIV_W-1:0] feedback_multiplier,
  input wire [`PLC_PRESCALE_W-1:0] prescale_setting,
  input wire loop_ref_tick,
  input wire loop_clock_run,
  input wire clock_output_pin_oe,
  input wire [`PLC_CLOCK_OUTPUT_PIN_RATE_W-1:0] clock_output_rate,
  input wire loop_locked
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  wire acc = psel && penable;
  wire en_wr = acc && pwrite && paddr == 18'h3c00c;
  wire mapped = paddr[1:0] == 2'h0 && paddr[17:2] >= `PLC_IDX_FB_DIV &&
    paddr[17:2] <= `PLC_IDX_CLK_OUT;
  // Run output lags the stored enable bit by one more cycle
  chk_run_follow: assert property (en_wr |-> ##2
    loop_run == $past(pwdata[0], 2))
    else $error("loop run does not follow enable write");
  chk_src_staged: assert property ($changed(core_clock_select)
    |=> $rose(loop_run))
    else $error("source changed without enable rise");
  chk_set_staged: assert property ($changed({feedback_multiplier,
    prescale_setting, clock_output_pin_oe, clock_output_rate})
    |=> $rose(loop_run))
    else $error("staged setting changed without enable rise");
  chk_idle_off: assert property (!loop_run && !$past(loop_run) |->
    !loop_clock_run && !loop_ref_tick && !loop_locked)
    else $error("loop active while disabled");
  chk_lock_cause: assert property ($rose(loop_locked) |-> $past(loop_run) &&
    $past(master_clock_stable) && feedback_multiplier != 0)
    else $error("lock without its prerequisites");
  chk_lock_settle: assert property ($rose(loop_run) |=> !loop_locked [*8])
    else $error("lock without settling time");
  chk_lock_read: assert property (acc && !pwrite && paddr == 18'h3c010 &&
    $stable(loop_locked) |-> prdata == {31'h0, loop_locked})
    else $error("lock register read wrong");
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr && pready)
    else $error("unmapped access not flagged");
  chk_tick_div8: assert property (loop_ref_tick && prescale_setting == 2'h3
    && loop_run |=> !loop_ref_tick [*7])
    else $error("divide by eight tick too early");
  cover property ($rose(loop_locked));
  cover property ($rose(core_clock_select));
  cover property (pslverr);
endmodule // plc_ctrl_sva
bind plc_ctrl plc_ctrl_sva #(.SETTLE_CYC(SETTLE_CYC)) plc_ctrl_sva_inst (
  .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata),
  .master_clock_stable(master_clock_stable),
  .core_clock_select(core_clock_select), .loop_run(loop_run),
  .feedback_multiplier(feedback_multiplier),
  .prescale_setting(prescale_setting), .loop_ref_tick(loop_ref_tick),
  .loop_clock_run(loop_clock_run),
  .clock_output_pin_oe(clock_output_pin_oe),
  .clock_output_rate(clock_output_rate), .loop_locked(loop_locked));
`default_nettype wire

// ---- testbench.sv ----
/* Bench for plc_ctrl: APB scenarios on staging, lock and prescale.
   Assumes plc_ctrl.v, plc_map.vh and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
`include "plc_map.vh"
module testbench;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic master_clock_stable = 1;
  logic [17:0] paddr = 0;
  logic [31:0] pwdata = 0, rdat;
  wire pready, pslverr, core_clock_select, loop_run, loop_ref_tick;
  wire loop_clock_run, clock_output_pin_oe, loop_locked;
  wire [31:0] prdata;
  wire [6:0] feedback_multiplier;
  wire [1:0] prescale_setting, clock_output_rate;
  int failures = 0, samples_checked = 0, n;
  // Short settle count keeps lock waits brief
  plc_ctrl #(.SETTLE_CYC(20)) plc_ctrl_inst (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata),
    .master_clock_stable(master_clock_stable),
    .core_clock_select(core_clock_select), .loop_run(loop_run),
    .feedback_multiplier(feedback_multiplier),
    .prescale_setting(prescale_setting), .loop_ref_tick(loop_ref_tick),
    .loop_clock_run(loop_clock_run),
    .clock_output_pin_oe(clock_output_pin_oe),
    .clock_output_rate(clock_output_rate), .loop_locked(loop_locked));
  always #10 clk = ~clk;
  task stop_test;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // Only the watchdog ends a stalled access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(negedge clk);
  endtask
  task rd(input logic [17:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(rdat, e);
  endtask
  task t_reset;
    chk({core_clock_select, loop_run, loop_locked, feedback_multiplier}, 'h60);
    rd('h3c008, 0);
    rd('h3c00c, 0);
    rd('h3c010, 0);
    rd('h3c000, 'h60);
    $display("reset test done");
  endtask
  task t_staged;
    apb(1, 'h3c008, 1);
    apb(1, 'h3c000, 'hff);
    apb(1, 'h3c014, 5);
    rd('h3c000, 'h7f);
    chk({core_clock_select, feedback_multiplier, clock_output_pin_oe}, 'hc0);
    apb(1, 'h3c00c, 1);
    chk({core_clock_select, feedback_multiplier, clock_output_pin_oe,
      clock_output_rate}, 'h7fe);
    n = 0;
    do begin
      apb(0, 'h3c010, 0);
      n++;
    end while (rdat[0] !== 1'b1 && n < 100);
    chk(rdat, 1);
    chk(loop_locked, 1);
    apb(1, 'h3c010, 0);
    rd('h3c010, 1);
    apb(1, 'h3c008, 0);
    apb(1, 'h3c00c, 1);
    chk(core_clock_select, 1);
    $display("staging test done");
  endtask
  task t_idle;
    apb(1, 'h3c00c, 0);
    repeat (3) @(negedge clk);
    chk({loop_run, loop_clock_run, loop_ref_tick, loop_locked}, 0);
    @(posedge clk) master_clock_stable <= 0;
    apb(1, 'h3c00c, 1);
    repeat (60) @(negedge clk);
    chk({core_clock_select, loop_locked}, 0);
    @(posedge clk) master_clock_stable <= 1;
    // Zero multiplier must never lock although the loop runs
    apb(1, 'h3c00c, 0);
    apb(1, 'h3c000, 0);
    apb(1, 'h3c00c, 1);
    repeat (40) @(negedge clk);
    chk({loop_clock_run, loop_locked}, 2);
    apb(1, 'h3c000, 'h60);
    $display("idle test done");
  endtask
  task t_prescale;
    for (int c = 0; c < 4; c++) begin
      apb(1, 'h3c00c, 0);
      apb(1, 'h3c004, c);
      apb(1, 'h3c00c, 1);
      chk(prescale_setting, c);
      n = 0;
      repeat (64) begin
        @(negedge clk);
        n += loop_ref_tick;
      end
      chk(n >= (64 >> c) - 1 && n <= (64 >> c) + 1, 1);
    end
    apb(0, 'h3c018, 0);
    chk(err, 1);
    chk(rdat, 0);
    $display("prescale and map test done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(negedge clk);
    t_reset;
    t_staged;
    t_idle;
    t_prescale;
    stop_test;
  end
  // Whole run needs well under two thousand cycles
  initial begin
    #100000;
    failures++;
    stop_test;
  end
endmodule // testbench
`default_nettype wire
